// >>> logic/usart_tx_params.svh
// register offsets, field positions, reset values and timing constants of the serial transmitter
`ifndef USART_TX_PARAMS_SVH
`define USART_TX_PARAMS_SVH

// register addresses (byte offsets in the data space)
`define ADDR_IRQ_FLAGS 8'h0c
`define ADDR_RX_CTRL 8'h18
`define ADDR_TX_BUFFER 8'h19
`define ADDR_IRQ_ENABLES 8'h8c
`define ADDR_TX_CTRL 8'h98
`define ADDR_BAUD_DIV 8'h99

// transmit_status_control fields
`define TXC_CLK_SRC 7
`define TXC_NINE_BIT 6
`define TXC_TX_ON 5
`define TXC_SYNC 4
`define TXC_HIGH_SPEED 2
`define TXC_SHIFT_EMPTY 1
`define TXC_NINTH 0

// receive_status_control fields
`define RXC_PORT_EN 7
`define RXC_RX_NINE 6
`define RXC_SINGLE_RX 5
`define RXC_CONT_RX 4

// irq flag / enable field of the transmitter
`define IRQ_TX_EMPTY 4

// reset values
`define RST_TX_CTRL 8'h02
`define RST_RX_CTRL 8'h00
`define RST_BYTE 8'h00

// ticks per bit: generator overflows per transmitted bit, less one
`define TICKS_HIGH_SPEED 6'h0f
`define TICKS_LOW_SPEED 6'h3f
`define TICKS_SYNC 6'h03

// bit counts of a frame: start + data + stop
`define FRAME_BITS_8 4'ha
`define FRAME_BITS_9 4'hb

// instruction cycle in oscillator periods, less one; load takes one instruction cycle
`define INSTR_CYCLE_CLKS 2'h3

`endif

// >>> logic/usart_tx_pkg.sv
// types shared by the serial transmitter
package usart_tx_pkg;
	typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} tx_state_e;
endpackage

// >>> logic/usart_baud_gen_async_tx.sv
// baud generator, receive-pin majority sampler and asynchronous transmitter
//
// Behaviour
// [RULE_01] 8-bit free-running baud timer, period set by baud divisor, shared by all modes.
// [RULE_02] async rate: clock/(64(div+1)) low speed, clock/(16(div+1)) high speed.
// [RULE_03] clocked master rate: clock/(4(div+1)); high-speed select ignored.
// [RULE_04] rates hold only as clock master; in slave the generator sets no rate.
// [RULE_05] writing the divisor resets the timer at once.
// [RULE_06] receive pin sampled three times mid-bit; level decided by majority.
// [RULE_07] frame: one start bit, eight or nine data bits, one stop bit, NRZ.
// [RULE_08] data bits go least significant first.
// [RULE_09] transmitter and receiver share frame format and bit rate.
// [RULE_10] generator clock is 16x bit rate high speed, 64x low speed.
// [RULE_11] no parity hardware; software may carry parity in ninth bit.
// [RULE_12] async when clocked-mode bit clear; async halted during sleep.
// [RULE_13] shifter loads from buffer after previous stop bit, taking one instruction cycle.
// [RULE_14] each load empties buffer and sets buffer-empty flag; only buffer write clears it.
// [RULE_15] setting transmitter-on sets buffer-empty flag; buffer write clears it.
// [RULE_16] read-only shifter-empty status at bit 1 of transmit control; shifter hidden.
// [RULE_17] frame starts only with buffer data and a generator shift clock.
// [RULE_18] buffer write into empty shifter passes straight through; back-to-back frames.
// [RULE_19] clearing transmitter-on mid-frame aborts, resets transmitter, tristates pin.
// [RULE_20] software writes ninth bit and nine-bit select before writing data.
// [RULE_21] software setup order: divisor, mode, port, irq, nine-bit, enable, ninth, data.
// [RULE_22] software may prefer high speed for lower rate error.
// [RULE_23] port enable and pin directions must be set to hand pins to the port.
// [RULE_24] generator held in reset while transmit and receive enables all clear.
// [RULE_25] line idles high; start low, stop high, each one bit period long.
// [RULE_26] timer reloads on overflow, one tick per divisor-plus-one counts.
`timescale 1ns/1ps
`include "usart_tx_params.svh"

module usart_baud_gen_async_tx #(
	parameter int DIV_W = 8
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	// chip state and pin directions
	input wire logic SLEEP,
	input wire logic [1:0] PORT_C_DIRECTION,
	// serial pins
	input wire logic RECEIVE_PIN,
	output logic TRANSMIT_PIN_O,
	output logic TRANSMIT_PIN_OE,
	// links to the receiver and synchronous logic
	output logic BAUD_TICK,
	output logic RX_BIT,
	output logic RX_BIT_VALID,
	output logic TX_EMPTY_IRQ
);

	// registers
	logic [7:0] tx_ctrl_r, tx_ctrl_nxt;
	logic [7:0] rx_ctrl_r, rx_ctrl_nxt;
	logic [7:0] tx_buf_r, tx_buf_nxt;
	logic [7:0] irq_en_r, irq_en_nxt;
	logic [DIV_W-1:0] baud_div_r, baud_div_nxt;
	logic buf_full_r, buf_full_nxt;
	logic tx_buffer_empty_flag_r, tx_buffer_empty_flag_nxt;
	logic [7:0] rdata_r, rdata_nxt;

	// generator
	logic [DIV_W-1:0] brg_cnt_r, brg_cnt_nxt;
	logic [5:0] pre_cnt_r, pre_cnt_nxt;
	logic brg_tick;
	logic bit_tick;
	logic brg_run;

	// sampler
	logic [1:0] rx_sync_r;
	logic [1:0] rx_sync_nxt;
	logic [2:0] votes_r, votes_nxt;
	logic rx_bit_r, rx_bit_nxt;
	logic rx_valid_r, rx_valid_nxt;

	// transmitter
	usart_tx_pkg::tx_state_e state_r, state_nxt;
	logic [10:0] shift_r, shift_nxt;
	logic [3:0] bits_left_r, bits_left_nxt;
	logic [1:0] load_cnt_r, load_cnt_nxt;
	logic line_r, line_nxt;
	logic oe_r, oe_nxt;

	logic wr_txc, wr_buf, wr_div;
	logic tx_on, async_mode, port_on;
	logic [5:0] ticks_per_bit;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target, input logic stb);
		hit = stb && (a == target);
	endfunction

	assign wr_txc = hit(REG_ADDR, `ADDR_TX_CTRL, REG_WR);
	assign wr_buf = hit(REG_ADDR, `ADDR_TX_BUFFER, REG_WR);
	assign wr_div = hit(REG_ADDR, `ADDR_BAUD_DIV, REG_WR);
	assign tx_on = tx_ctrl_r[`TXC_TX_ON];
	// async only with clocked mode clear and chip awake
	assign async_mode = !tx_ctrl_r[`TXC_SYNC] && !SLEEP; // [RULE_12]
	assign port_on = rx_ctrl_r[`RXC_PORT_EN] && (&PORT_C_DIRECTION); // [RULE_23]
	// generator runs only with some enable set
	assign brg_run = tx_on || rx_ctrl_r[`RXC_CONT_RX] || rx_ctrl_r[`RXC_SINGLE_RX]; // [RULE_24]

	// ticks per bit: x16/x64 async, x4 clocked master; high speed ignored in clocked mode
	always_comb begin
		if (tx_ctrl_r[`TXC_SYNC]) begin
			ticks_per_bit = `TICKS_SYNC; // [RULE_03]
		end else if (tx_ctrl_r[`TXC_HIGH_SPEED]) begin
			ticks_per_bit = `TICKS_HIGH_SPEED; // [RULE_02] [RULE_10]
		end else begin
			ticks_per_bit = `TICKS_LOW_SPEED; // [RULE_02] [RULE_10]
		end
	end

	// baud timer: counts down from divisor, reloads on overflow
	assign brg_tick = brg_run && !SLEEP && (brg_cnt_r == '0); // [RULE_01] [RULE_26]
	// clocked slave takes its clock from the pin, so no internal bit tick then
	assign bit_tick = brg_tick && (pre_cnt_r == '0) && (tx_ctrl_r[`TXC_CLK_SRC] || !tx_ctrl_r[`TXC_SYNC]); // [RULE_04]

	always_comb begin
		brg_cnt_nxt = brg_cnt_r;
		pre_cnt_nxt = pre_cnt_r;
		if (!brg_run || wr_div) begin
			// divisor write restarts timing at once
			brg_cnt_nxt = wr_div ? REG_WDATA[DIV_W-1:0] : baud_div_r; // [RULE_05] [RULE_24]
			pre_cnt_nxt = ticks_per_bit;
		end else if (!SLEEP) begin
			if (brg_cnt_r == '0) begin
				brg_cnt_nxt = baud_div_r; // [RULE_26]
				pre_cnt_nxt = (pre_cnt_r == '0) ? ticks_per_bit : pre_cnt_r - 6'h01;
			end else begin
				brg_cnt_nxt = brg_cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			brg_cnt_r <= '0;
			pre_cnt_r <= '0;
		end else begin
			brg_cnt_r <= brg_cnt_nxt;
			pre_cnt_r <= pre_cnt_nxt;
		end
	end

	// receive sampler: three votes at the middle ticks of each bit
	logic mid_a, mid_b, mid_c;
	logic [5:0] half;
	assign half = {1'b0, ticks_per_bit[5:1]};
	assign mid_a = brg_tick && (pre_cnt_r == half + 6'h01);
	assign mid_b = brg_tick && (pre_cnt_r == half);
	assign mid_c = brg_tick && (pre_cnt_r == half - 6'h01);

	always_comb begin
		rx_sync_nxt = {rx_sync_r[0], RECEIVE_PIN};
		votes_nxt = votes_r;
		rx_bit_nxt = rx_bit_r;
		rx_valid_nxt = 1'b0;
		if (mid_a) begin
			votes_nxt[0] = rx_sync_r[1]; // [RULE_06]
		end
		if (mid_b) begin
			votes_nxt[1] = rx_sync_r[1]; // [RULE_06]
		end
		if (mid_c) begin
			// majority of the two stored votes and this sample
			rx_bit_nxt = (votes_r[0] & votes_r[1]) | (votes_r[0] & rx_sync_r[1]) | (votes_r[1] & rx_sync_r[1]); // [RULE_06]
			rx_valid_nxt = async_mode; // [RULE_09]
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rx_sync_r <= 2'h3;
			votes_r <= 3'h7;
			rx_bit_r <= 1'b1;
			rx_valid_r <= 1'b0;
		end else begin
			rx_sync_r <= rx_sync_nxt;
			votes_r <= votes_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_valid_r <= rx_valid_nxt;
		end
	end

	// transmitter: buffer to shifter, then frame out on bit ticks
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bits_left_nxt = bits_left_r;
		load_cnt_nxt = load_cnt_r;
		line_nxt = line_r;
		oe_nxt = port_on && tx_on && async_mode;
		buf_full_nxt = buf_full_r;
		tx_buffer_empty_flag_nxt = tx_buffer_empty_flag_r;
		if (wr_buf) begin
			buf_full_nxt = 1'b1;
			tx_buffer_empty_flag_nxt = 1'b0; // [RULE_14] [RULE_15]
		end
		if (wr_txc && REG_WDATA[`TXC_TX_ON] && !tx_on) begin
			tx_buffer_empty_flag_nxt = 1'b1; // [RULE_15]
		end
		if (!tx_on) begin
			// abort: transmitter reset, pin released
			state_nxt = usart_tx_pkg::TX_IDLE; // [RULE_19]
			line_nxt = 1'b1;
			oe_nxt = 1'b0; // [RULE_19]
			bits_left_nxt = '0;
		end else begin
			unique case (state_r)
				usart_tx_pkg::TX_IDLE: begin
					line_nxt = 1'b1; // [RULE_25]
					if (buf_full_r && async_mode) begin
						state_nxt = usart_tx_pkg::TX_LOAD; // [RULE_13] [RULE_18]
						load_cnt_nxt = `INSTR_CYCLE_CLKS;
					end
				end
				usart_tx_pkg::TX_LOAD: begin
					if (load_cnt_r == 2'h0) begin
						// stop, ninth/ninth-less data, start: lsb first
						shift_nxt = tx_ctrl_r[`TXC_NINE_BIT] ?
							{1'b1, tx_ctrl_r[`TXC_NINTH], tx_buf_r, 1'b0} :
							{1'b1, 1'b1, tx_buf_r, 1'b0}; // [RULE_07] [RULE_08] [RULE_11] [RULE_20]
						bits_left_nxt = tx_ctrl_r[`TXC_NINE_BIT] ? `FRAME_BITS_9 : `FRAME_BITS_8; // [RULE_07]
						buf_full_nxt = wr_buf; // [RULE_14]
						tx_buffer_empty_flag_nxt = !wr_buf; // [RULE_14]
						state_nxt = usart_tx_pkg::TX_SHIFT;
					end else begin
						load_cnt_nxt = load_cnt_r - 2'h1; // [RULE_13]
					end
				end
				usart_tx_pkg::TX_SHIFT: begin
					// first edge waits for a generator shift clock
					if (bit_tick && async_mode) begin // [RULE_17]
						if (bits_left_r == 4'h0) begin
							// stop bit has gone out
							line_nxt = 1'b1;
							state_nxt = usart_tx_pkg::TX_IDLE; // [RULE_13]
							if (buf_full_r) begin
								state_nxt = usart_tx_pkg::TX_LOAD; // [RULE_18]
								load_cnt_nxt = `INSTR_CYCLE_CLKS;
							end
						end else begin
							line_nxt = shift_r[0]; // [RULE_25] [RULE_08]
							shift_nxt = {1'b1, shift_r[10:1]};
							bits_left_nxt = bits_left_r - 4'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state_r <= usart_tx_pkg::TX_IDLE;
			shift_r <= '1;
			bits_left_r <= '0;
			load_cnt_r <= '0;
			line_r <= 1'b1;
			oe_r <= 1'b0;
			buf_full_r <= 1'b0;
			tx_buffer_empty_flag_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bits_left_r <= bits_left_nxt;
			load_cnt_r <= load_cnt_nxt;
			line_r <= line_nxt;
			oe_r <= oe_nxt;
			buf_full_r <= buf_full_nxt;
			tx_buffer_empty_flag_r <= tx_buffer_empty_flag_nxt;
		end
	end

	// register file
	logic shifter_empty;
	assign shifter_empty = (state_r != usart_tx_pkg::TX_SHIFT); // [RULE_16]

	always_comb begin
		tx_ctrl_nxt = tx_ctrl_r;
		rx_ctrl_nxt = rx_ctrl_r;
		tx_buf_nxt = tx_buf_r;
		irq_en_nxt = irq_en_r;
		baud_div_nxt = baud_div_r;
		rdata_nxt = 8'h00;
		if (wr_txc) begin
			// bit 3 unimplemented, bit 1 read-only
			tx_ctrl_nxt = {REG_WDATA[7:4], 1'b0, REG_WDATA[`TXC_HIGH_SPEED], 1'b0, REG_WDATA[`TXC_NINTH]}; // [RULE_16]
		end
		if (hit(REG_ADDR, `ADDR_RX_CTRL, REG_WR)) begin
			rx_ctrl_nxt = {REG_WDATA[7:4], 4'h0};
		end
		if (wr_buf) begin
			tx_buf_nxt = REG_WDATA;
		end
		if (hit(REG_ADDR, `ADDR_IRQ_ENABLES, REG_WR)) begin
			irq_en_nxt = REG_WDATA;
		end
		if (wr_div) begin
			baud_div_nxt = REG_WDATA[DIV_W-1:0];
		end
		if (REG_RD) begin
			unique case (REG_ADDR)
				`ADDR_TX_CTRL: rdata_nxt = {tx_ctrl_r[7:2], shifter_empty, tx_ctrl_r[0]}; // [RULE_16]
				`ADDR_RX_CTRL: rdata_nxt = rx_ctrl_r;
				`ADDR_TX_BUFFER: rdata_nxt = tx_buf_r;
				`ADDR_IRQ_ENABLES: rdata_nxt = irq_en_r;
				`ADDR_BAUD_DIV: rdata_nxt = 8'(baud_div_r);
				// flag is read-only: writes to the flag register cannot clear it, only a buffer write does
				`ADDR_IRQ_FLAGS: rdata_nxt = 8'(tx_buffer_empty_flag_r) << `IRQ_TX_EMPTY; // [RULE_14]
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			tx_ctrl_r <= `RST_TX_CTRL & ~(8'h01 << `TXC_SHIFT_EMPTY);
			rx_ctrl_r <= `RST_RX_CTRL;
			tx_buf_r <= `RST_BYTE;
			irq_en_r <= `RST_BYTE;
			baud_div_r <= '0;
			rdata_r <= 8'h00;
		end else begin
			tx_ctrl_r <= tx_ctrl_nxt;
			rx_ctrl_r <= rx_ctrl_nxt;
			tx_buf_r <= tx_buf_nxt;
			irq_en_r <= irq_en_nxt;
			baud_div_r <= baud_div_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign REG_RDATA = rdata_r;
	assign TRANSMIT_PIN_O = line_r;
	assign TRANSMIT_PIN_OE = oe_r;
	assign BAUD_TICK = brg_tick;
	assign RX_BIT = rx_bit_r;
	assign RX_BIT_VALID = rx_valid_r;
	assign TX_EMPTY_IRQ = tx_buffer_empty_flag_r && irq_en_r[`IRQ_TX_EMPTY];

endmodule

// >>> tb/usart_tx_chk.sv
// assertions on the ports of the baud generator and transmitter
`timescale 1ns/1ps
module usart_tx_chk (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	// pins and links
	input wire logic SLEEP,
	input wire logic TRANSMIT_PIN_O,
	input wire logic TRANSMIT_PIN_OE,
	input wire logic BAUD_TICK,
	input wire logic TX_EMPTY_IRQ
);
	logic ie_r, ie_nxt, on_r, on_nxt, clean_r, clean_nxt;
	logic [7:0] div_r, div_nxt, gap_r, gap_nxt;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	always_comb begin
		ie_nxt = ie_r;
		on_nxt = on_r;
		div_nxt = div_r;
		if (REG_WR && REG_ADDR == 8'h8c)
			ie_nxt = REG_WDATA[4];
		if (REG_WR && REG_ADDR == 8'h98)
			on_nxt = REG_WDATA[5];
		if (REG_WR && REG_ADDR == 8'h99)
			div_nxt = REG_WDATA;
		// a write may restart the timer, so only untouched periods are measured
		clean_nxt = (clean_r || BAUD_TICK) && !REG_WR && !SLEEP;
		gap_nxt = BAUD_TICK ? 8'h00 : gap_r + 8'h01;
	end
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			ie_r <= 1'h0;
			on_r <= 1'h0;
			clean_r <= 1'h0;
			div_r <= 8'h00;
			gap_r <= 8'h00;
		end else begin
			ie_r <= ie_nxt;
			on_r <= on_nxt;
			clean_r <= clean_nxt;
			div_r <= div_nxt;
			gap_r <= gap_nxt;
		end
	end
	a_tick_period: assert property (BAUD_TICK && clean_r |-> gap_r == div_r)
		else $error("tick spacing differs from divisor");
	a_div_restart: assert property (REG_WR && REG_ADDR == 8'h99 && REG_WDATA == 8'h03 && on_r |-> ##[1:5] BAUD_TICK)
		else $error("divisor write did not restart timer");
	a_abort_oe: assert property (REG_WR && REG_ADDR == 8'h98 && !REG_WDATA[5] |-> ##[1:2] !TRANSMIT_PIN_OE)
		else $error("pin still driven after transmitter off");
	a_idle_high: assert property (!TRANSMIT_PIN_OE |-> TRANSMIT_PIN_O)
		else $error("line not high while released");
	a_bit_hold: assert property ($fell(TRANSMIT_PIN_O) && TRANSMIT_PIN_OE |=> !TRANSMIT_PIN_O [*8])
		else $error("low bit shorter than a bit period");
	a_irq_mask: assert property (!ie_r |-> !TX_EMPTY_IRQ)
		else $error("irq raised while disabled");
	a_irq_clear: assert property (REG_WR && REG_ADDR == 8'h19 |=> !TX_EMPTY_IRQ)
		else $error("buffer write left flag set");
	a_ton_flag: assert property (REG_WR && REG_ADDR == 8'h98 && REG_WDATA[5] && !on_r && ie_r |=> TX_EMPTY_IRQ)
		else $error("transmitter on did not set flag");
	a_flag_read: assert property (REG_RD && REG_ADDR == 8'h0c && ie_r |=> REG_RDATA == {3'h0, $past(TX_EMPTY_IRQ), 4'h0})
		else $error("flag register read wrong");
endmodule
bind usart_baud_gen_async_tx usart_tx_chk i_usart_tx_chk (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SLEEP(SLEEP),
	.TRANSMIT_PIN_O(TRANSMIT_PIN_O), .TRANSMIT_PIN_OE(TRANSMIT_PIN_OE), .BAUD_TICK(BAUD_TICK),
	.TX_EMPTY_IRQ(TX_EMPTY_IRQ));

// >>> tb/serial_peer.sv
// remote serial device decoding frames on the transmit line
`timescale 1ns/1ps
module serial_peer (
	// clock and line
	input wire logic CLK,
	input wire logic line,
	// frame format
	input wire logic nine,
	input int bitclk,
	// decoded frame
	output logic [8:0] data,
	output int frames
);
	logic [8:0] sr;
	initial frames = 0;
	always begin
		@(negedge line);
		repeat (bitclk / 2) @(posedge CLK);
		if (line === 1'h0) begin // start bit low
			sr = 9'h000;
			for (int i = 0; i < (nine ? 9 : 8); i++) begin // lsb first
				repeat (bitclk) @(posedge CLK);
				sr[i] = line;
			end
			repeat (bitclk) @(posedge CLK);
			data = (line === 1'h1) ? sr : 9'hxxx; // one stop bit
			frames++;
		end
	end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the baud generator and transmitter
`timescale 1ns/1ps
module tb_top;
	logic CLK = 1'h0, RESET_N = 1'h0, REG_WR = 1'h0, REG_RD = 1'h0, nine = 1'h0;
	logic TRANSMIT_PIN_O, TRANSMIT_PIN_OE, line;
	logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
	logic [7:0] regs [7] = '{8'h0c, 8'h18, 8'h19, 8'h8c, 8'h98, 8'h99, 8'h55};
	logic [8:0] rx_data;
	logic rx_bit;
	int num_errors = 0, checks_done = 0, rx_frames, bitclk = 32;
	// pull-up holds the line while the pin is released
	assign line = TRANSMIT_PIN_OE ? TRANSMIT_PIN_O : 1'h1;
	usart_baud_gen_async_tx i_usart_baud_gen_async_tx (.CLK(CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SLEEP(1'h0),
		.PORT_C_DIRECTION(2'h3), .RECEIVE_PIN(line), .TRANSMIT_PIN_O(TRANSMIT_PIN_O),
		.TRANSMIT_PIN_OE(TRANSMIT_PIN_OE), .BAUD_TICK(), .RX_BIT(rx_bit), .RX_BIT_VALID(), .TX_EMPTY_IRQ());
	serial_peer i_serial_peer (.CLK(CLK), .line(line), .nine(nine), .bitclk(bitclk), .data(rx_data),
		.frames(rx_frames));
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'h1;
		@(posedge CLK);
		REG_WR <= 1'h0;
		@(posedge CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		REG_ADDR <= a;
		REG_RD <= 1'h1;
		@(posedge CLK);
		REG_RD <= 1'h0;
		#1;
		chk($sformatf("reg %h", a), {1'h0, exp}, {1'h0, REG_RDATA});
		@(posedge CLK);
	endtask
	task automatic frame(input logic [8:0] exp);
		int n;
		n = rx_frames + 1;
		for (int i = 0; i < 3000 && rx_frames < n; i++)
			@(posedge CLK);
		chk("frame", exp, rx_data);
	endtask
	task automatic results;
		if (num_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		forever #2 CLK = ~CLK;
	end
	initial begin
		repeat (20000) @(posedge CLK);
		num_errors++;
		results;
	end
	initial begin
		repeat (6) @(posedge CLK);
		RESET_N <= 1'h1;
		@(posedge CLK);
		foreach (regs[i])
			rd(regs[i], i == 4 ? 8'h02 : 8'h00);
		wr(8'h99, 8'h01);
		wr(8'h18, 8'h80);
		wr(8'h8c, 8'h10);
		wr(8'h98, 8'h24);
		rd(8'h0c, 8'h10);
		wr(8'h19, 8'ha5);
		repeat (10) @(posedge CLK);
		wr(8'h19, 8'h3c);
		repeat (30) @(posedge CLK);
		rd(8'h0c, 8'h00);
		rd(8'h98, 8'h24);
		frame(9'h0a5);
		frame(9'h03c);
		repeat (40) @(posedge CLK);
		rd(8'h98, 8'h26);
		nine <= 1'h1;
		wr(8'h98, 8'h65);
		wr(8'h19, 8'h5a);
		frame(9'h15a);
		wr(8'h19, 8'hff);
		repeat (100) @(posedge CLK);
		wr(8'h98, 8'h00);
		#1;
		chk("pin enable", 9'h000, {8'h00, TRANSMIT_PIN_OE});
		rd(8'h98, 8'h02);
		// the aborted frame still reaches the peer as ones
		repeat (400) @(posedge CLK);
		nine <= 1'h0;
		wr(8'h98, 8'h24);
		wr(8'h99, 8'hc8);
		repeat (20) @(posedge CLK);
		wr(8'h99, 8'h03);
		repeat (20) @(posedge CLK);
		wr(8'h99, 8'h00);
		wr(8'h98, 8'h20);
		bitclk = 64;
		wr(8'h19, 8'h81);
		frame(9'h081);
		// all three last votes fell in the high ninth-less msb, not yet in the stop bit
		chk("rx bit", 9'h001, {8'h00, rx_bit});
		results;
	end
endmodule
